// ---- dv/smc_checker.sv ----
// Port-level assertions for the supply monitor control block
`timescale 1ns/1ns
module smc_checker (
	input wire MCLK_I, // Clock
	input wire RESETN_I, // Full reset, active low
	input wire SOFT_RESETN_I, // Soft reset, active low
	input wire PROTECT_WRITE_ENABLE_I, // Write-protect release
	input wire WR_DET_EN_I, // Enable register strobe
	input wire WR_LVD_CTRL_I, // Interrupt control strobe
	input wire WR_BOR_CTRL_I, // Brown-out control strobe
	input wire DET0_ENABLE_I, // Write data
	input wire LVD_CROSSED_FLAG_I, // Write data
	input wire WDT_IRQ_I, // Watchdog interrupt
	input wire OSC_IRQ_I, // Oscillation interrupt
	input wire DET0_ENABLE_O, // Readback
	input wire LVD_ENABLE_O, // Readback
	input wire VCC_ABOVE_LEVEL_O, // Level status
	input wire LVD_CROSSED_FLAG_O, // Sticky flag
	input wire BOR_ENABLE_O, // Readback
	input wire BOR_RESET_O, // Brown-out reset
	input wire SHARED_IRQ_O, // Shared request
	input wire WAKE_O // Wake pulse
);
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!RESETN_I);
	a_prot_write_ignored: assert property (!PROTECT_WRITE_ENABLE_I |=> $stable(DET0_ENABLE_O))
		else $error("enable changed while protected");
	a_write_taken: assert property (PROTECT_WRITE_ENABLE_I && WR_DET_EN_I
		|=> DET0_ENABLE_O == $past(DET0_ENABLE_I)) else $error("enable write lost");
	a_soft_keeps_enable: assert property (!SOFT_RESETN_I && !WR_DET_EN_I && !WR_BOR_CTRL_I
		|=> $stable(LVD_ENABLE_O) && $stable(BOR_ENABLE_O)) else $error("soft reset hit enables");
	a_settle_gates_flag: assert property ($rose(LVD_ENABLE_O) |-> !LVD_CROSSED_FLAG_O [*8])
		else $error("flag set during settle");
	a_flag_off_held: assert property (!LVD_ENABLE_O && !$past(LVD_ENABLE_O)
		|-> !LVD_CROSSED_FLAG_O) else $error("flag set while detector off");
	a_flag_sticky: assert property (LVD_CROSSED_FLAG_O && LVD_ENABLE_O && SOFT_RESETN_I
		&& !WR_DET_EN_I && !(WR_LVD_CTRL_I && PROTECT_WRITE_ENABLE_I && !LVD_CROSSED_FLAG_I)
		|=> LVD_CROSSED_FLAG_O) else $error("flag dropped without clear");
	a_level_off_high: assert property (!LVD_ENABLE_O && !$past(LVD_ENABLE_O)
		|-> VCC_ABOVE_LEVEL_O) else $error("level low while detector off");
	a_irq_merged: assert property ((WDT_IRQ_I || OSC_IRQ_I) && SOFT_RESETN_I
		|=> SHARED_IRQ_O) else $error("shared request missing");
	a_bor_needs_det0: assert property ((!DET0_ENABLE_O) [*8] |-> !BOR_RESET_O)
		else $error("brown-out reset without detector 0");
	a_wake_single: assert property (WAKE_O |=> !WAKE_O)
		else $error("wake longer than one cycle");
endmodule // smc_checker

// ---- dv/testbench.sv ----
// Self-checking bench for the supply monitor control block
`timescale 1ns/1ns
module testbench;
	logic MCLK_I, RESETN_I, SOFT_RESETN_I, PROTECT_WRITE_ENABLE_I, WR_DET_EN_I;
	logic DET0_ENABLE_I, LVD_ENABLE_I, WR_LVD_CTRL_I, LVD_IRQ_ENABLE_I, LVD_WAKE_ENABLE_I;
	logic LVD_CROSSED_FLAG_I, WR_BOR_CTRL_I, BOR_ENABLE_I, BOR_FILTER_DISABLE_I;
	logic PERIPH_CLK_STOP_IN_WAIT_I, LOWSPEED_OSC_STOP_I, LOSC_TICK_I, DET0_CMP_I, WARN_CMP_I;
	logic WDT_IRQ_I, OSC_IRQ_I, DET0_ENABLE_O, LVD_ENABLE_O, VCC_ABOVE_LEVEL_O, LVD_IRQ_ENABLE_O;
	logic LVD_WAKE_ENABLE_O, LVD_CROSSED_FLAG_O, BOR_ENABLE_O, BOR_FILTER_DISABLE_O;
	logic BOR_RESET_O, SHARED_IRQ_O, WAKE_O, got;
	logic [1:0] LVD_SAMPLE_DIV_I, BOR_FILTER_CLK_SEL_I, POWER_MODE_I, LVD_SAMPLE_DIV_O;
	logic [1:0] BOR_FILTER_CLK_SEL_O, lc;
	int bad_count = 0, compares = 0;
	smc_top dut_u (.MCLK_I(MCLK_I), .RESETN_I(RESETN_I), .SOFT_RESETN_I(SOFT_RESETN_I),
		.PROTECT_WRITE_ENABLE_I(PROTECT_WRITE_ENABLE_I), .WR_DET_EN_I(WR_DET_EN_I),
		.DET0_ENABLE_I(DET0_ENABLE_I), .LVD_ENABLE_I(LVD_ENABLE_I), .WR_LVD_CTRL_I(WR_LVD_CTRL_I),
		.LVD_IRQ_ENABLE_I(LVD_IRQ_ENABLE_I), .LVD_WAKE_ENABLE_I(LVD_WAKE_ENABLE_I),
		.LVD_CROSSED_FLAG_I(LVD_CROSSED_FLAG_I), .LVD_SAMPLE_DIV_I(LVD_SAMPLE_DIV_I),
		.WR_BOR_CTRL_I(WR_BOR_CTRL_I), .BOR_ENABLE_I(BOR_ENABLE_I),
		.BOR_FILTER_DISABLE_I(BOR_FILTER_DISABLE_I), .BOR_FILTER_CLK_SEL_I(BOR_FILTER_CLK_SEL_I),
		.PERIPH_CLK_STOP_IN_WAIT_I(PERIPH_CLK_STOP_IN_WAIT_I), .LOSC_TICK_I(LOSC_TICK_I),
		.LOWSPEED_OSC_STOP_I(LOWSPEED_OSC_STOP_I), .POWER_MODE_I(POWER_MODE_I),
		.DET0_CMP_I(DET0_CMP_I), .WARN_CMP_I(WARN_CMP_I), .WDT_IRQ_I(WDT_IRQ_I),
		.OSC_IRQ_I(OSC_IRQ_I), .DET0_ENABLE_O(DET0_ENABLE_O), .LVD_ENABLE_O(LVD_ENABLE_O),
		.VCC_ABOVE_LEVEL_O(VCC_ABOVE_LEVEL_O), .LVD_IRQ_ENABLE_O(LVD_IRQ_ENABLE_O),
		.LVD_WAKE_ENABLE_O(LVD_WAKE_ENABLE_O), .LVD_CROSSED_FLAG_O(LVD_CROSSED_FLAG_O),
		.LVD_SAMPLE_DIV_O(LVD_SAMPLE_DIV_O), .BOR_ENABLE_O(BOR_ENABLE_O),
		.BOR_FILTER_DISABLE_O(BOR_FILTER_DISABLE_O), .BOR_FILTER_CLK_SEL_O(BOR_FILTER_CLK_SEL_O),
		.BOR_RESET_O(BOR_RESET_O), .SHARED_IRQ_O(SHARED_IRQ_O), .WAKE_O(WAKE_O));
	initial begin
		MCLK_I = 0;
		forever #5 MCLK_I = ~MCLK_I;
	end
	// Low-speed tick every fourth clock, free running
	always @(posedge MCLK_I) begin
		#1 lc = lc + 2'h1;
		LOSC_TICK_I = (lc == 2'h0);
	end
	task automatic chk(input logic [1:0] g, input logic [1:0] e);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge MCLK_I);
		#1;
	endtask
	task automatic wdet(input logic a, input logic b);
		cyc(1); DET0_ENABLE_I = a; LVD_ENABLE_I = b; WR_DET_EN_I = 1;
		cyc(1); WR_DET_EN_I = 0;
	endtask
	task automatic wlvd(input logic irq, input logic wk, input logic fl, input logic [1:0] dv);
		cyc(1); LVD_IRQ_ENABLE_I = irq; LVD_WAKE_ENABLE_I = wk; LVD_CROSSED_FLAG_I = fl;
		LVD_SAMPLE_DIV_I = dv; WR_LVD_CTRL_I = 1;
		cyc(1); WR_LVD_CTRL_I = 0;
	endtask
	task automatic wbor(input logic en, input logic fd, input logic [1:0] cs);
		cyc(1); BOR_ENABLE_I = en; BOR_FILTER_DISABLE_I = fd; BOR_FILTER_CLK_SEL_I = cs;
		WR_BOR_CTRL_I = 1;
		cyc(1); WR_BOR_CTRL_I = 0;
	endtask
	// Bounded wait: 0 flag, 1 shared request, 2 wake, 3 brown-out reset
	task automatic wait_hi(input int k, input int lim);
		got = 0;
		repeat (lim) if (got !== 1'b1) begin
			cyc(1);
			got = (k == 0) ? LVD_CROSSED_FLAG_O : (k == 1) ? SHARED_IRQ_O : (k == 2) ? WAKE_O : BOR_RESET_O;
		end
		chk(got, 2'h1);
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		#300000 bad_count++;
		wrap_up;
	end
	initial begin
		{RESETN_I, PROTECT_WRITE_ENABLE_I, WR_DET_EN_I, DET0_ENABLE_I, LVD_ENABLE_I} = 0;
		{WR_LVD_CTRL_I, LVD_IRQ_ENABLE_I, LVD_WAKE_ENABLE_I, LVD_CROSSED_FLAG_I, WR_BOR_CTRL_I} = 0;
		{BOR_ENABLE_I, BOR_FILTER_DISABLE_I, PERIPH_CLK_STOP_IN_WAIT_I, WDT_IRQ_I, OSC_IRQ_I} = 0;
		{LVD_SAMPLE_DIV_I, BOR_FILTER_CLK_SEL_I, POWER_MODE_I, lc, LOSC_TICK_I} = 0;
		{SOFT_RESETN_I, LOWSPEED_OSC_STOP_I, DET0_CMP_I, WARN_CMP_I} = 4'hf;
		cyc(20); RESETN_I = 1;
		chk({VCC_ABOVE_LEVEL_O, BOR_FILTER_DISABLE_O}, 2'h3);
		wdet(1, 1); chk({DET0_ENABLE_O, LVD_ENABLE_O}, 2'h0);
		PROTECT_WRITE_ENABLE_I = 1;
		wdet(1, 1); chk({DET0_ENABLE_O, LVD_ENABLE_O}, 2'h3);
		for (int i = 3; i >= 0; i--) begin
			wlvd(0, 0, 1, i[1:0]); chk(LVD_SAMPLE_DIV_O, i[1:0]);
		end
		cyc(30); WARN_CMP_I = 0; wait_hi(0, 300);
		cyc(3); chk(VCC_ABOVE_LEVEL_O, 2'h0);
		wlvd(0, 0, 1, 0); chk(LVD_CROSSED_FLAG_O, 2'h1);
		wlvd(0, 0, 0, 0); chk(LVD_CROSSED_FLAG_O, 2'h0);
		wlvd(1, 0, 1, 0); WARN_CMP_I = 1; wait_hi(1, 300);
		wlvd(1, 0, 0, 0); WARN_CMP_I = 0; wait_hi(1, 300);
		for (int i = 1; i < 3; i++) begin
			cyc(1); {OSC_IRQ_I, WDT_IRQ_I} = i[1:0];
			cyc(1); {OSC_IRQ_I, WDT_IRQ_I} = 0; chk(SHARED_IRQ_O, 2'h1);
		end
		POWER_MODE_I = 2'h2; wlvd(1, 0, 0, 0); wlvd(1, 1, 1, 0);
		chk({LVD_IRQ_ENABLE_O, LVD_WAKE_ENABLE_O}, 2'h3);
		WARN_CMP_I = 1; wait_hi(2, 300);
		POWER_MODE_I = 2'h1; PERIPH_CLK_STOP_IN_WAIT_I = 1; WARN_CMP_I = 0;
		cyc(60); wlvd(1, 0, 1, 0); wlvd(1, 1, 1, 0);
		WARN_CMP_I = 1; wait_hi(2, 300);
		POWER_MODE_I = 0; PERIPH_CLK_STOP_IN_WAIT_I = 0;
		wbor(1, 1, 2'h0); DET0_CMP_I = 0; wait_hi(3, 50);
		DET0_CMP_I = 1; cyc(50); wbor(0, 0, 2'h3);
		LOWSPEED_OSC_STOP_I = 0; cyc(130);
		wbor(1, 0, 2'h3); DET0_CMP_I = 0; cyc(100); chk(BOR_RESET_O, 2'h0);
		wait_hi(3, 300);
		DET0_CMP_I = 1; cyc(100); SOFT_RESETN_I = 0; cyc(2); SOFT_RESETN_I = 1;
		chk({DET0_ENABLE_O, LVD_ENABLE_O}, 2'h3);
		chk({BOR_ENABLE_O, BOR_FILTER_DISABLE_O}, 2'h2);
		chk(BOR_FILTER_CLK_SEL_O, 2'h3);
		wlvd(0, 0, 1, 3); chk(LVD_SAMPLE_DIV_O, 2'h3);
		WARN_CMP_I = 0; cyc(100); chk(LVD_CROSSED_FLAG_O, 2'h0);
		wait_hi(0, 300);
		wdet(0, 0); DET0_CMP_I = 0; cyc(40); chk(BOR_RESET_O, 2'h0);
		chk({LVD_CROSSED_FLAG_O, VCC_ABOVE_LEVEL_O}, 2'h1);
		wrap_up;
	end
endmodule // testbench
bind smc_top smc_checker chk_u (.MCLK_I(MCLK_I), .RESETN_I(RESETN_I),
	.SOFT_RESETN_I(SOFT_RESETN_I), .PROTECT_WRITE_ENABLE_I(PROTECT_WRITE_ENABLE_I),
	.WR_DET_EN_I(WR_DET_EN_I), .WR_LVD_CTRL_I(WR_LVD_CTRL_I), .WR_BOR_CTRL_I(WR_BOR_CTRL_I),
	.DET0_ENABLE_I(DET0_ENABLE_I), .LVD_CROSSED_FLAG_I(LVD_CROSSED_FLAG_I),
	.WDT_IRQ_I(WDT_IRQ_I), .OSC_IRQ_I(OSC_IRQ_I), .DET0_ENABLE_O(DET0_ENABLE_O),
	.LVD_ENABLE_O(LVD_ENABLE_O), .VCC_ABOVE_LEVEL_O(VCC_ABOVE_LEVEL_O),
	.LVD_CROSSED_FLAG_O(LVD_CROSSED_FLAG_O), .BOR_ENABLE_O(BOR_ENABLE_O),
	.BOR_RESET_O(BOR_RESET_O), .SHARED_IRQ_O(SHARED_IRQ_O), .WAKE_O(WAKE_O));

// ---- rtl/smc_consts.vh ----
// Constants for the supply monitor control block
`ifndef SMC_CONSTS_VH
`define SMC_CONSTS_VH
`define SMC_SETTLE_NS 32'd100
`define SMC_CLK_NS 32'd10
`define SMC_SETTLE_CYC ((`SMC_SETTLE_NS + `SMC_CLK_NS - 32'd1) / `SMC_CLK_NS)
`define SMC_SETTLE_W 8
`define SMC_DIV_W 6
`define SMC_DIV8 6'h07
`define SMC_DIV16 6'h0f
`define SMC_DIV32 6'h1f
`define SMC_DIV64 6'h3f
`define SMC_FILT_W 2
`define SMC_FILT_LAST 2'h3
`define SMC_LOSC_DIV_W 3
`define SMC_MODE_NORMAL 2'h0
`define SMC_MODE_WAIT 2'h1
`define SMC_MODE_STOP 2'h2
`endif

// ---- rtl/smc_settle.v ----
// Settle counter that holds a detector output off after enable
`timescale 1ns/1ns
`include "smc_consts.vh"
module smc_settle (
	input wire clk_i, // Clock
	input wire rst_n_i, // Sync reset, active low
	input wire en_i, // Detector enable
	output reg ready_o // Settle time elapsed
);
	reg [`SMC_SETTLE_W-1:0] cnt;
	always @(posedge clk_i) begin
		if (!rst_n_i || !en_i) begin
			cnt <= {`SMC_SETTLE_W{1'b0}};
			ready_o <= 1'b0;
		end else if (cnt >= `SMC_SETTLE_CYC - 1) begin
			ready_o <= 1'b1;
		end else begin
			cnt <= cnt + 1'b1;
		end
	end
endmodule // smc_settle

// ---- rtl/smc_sync.v ----
// Two-flop synchroniser taken on a sampling strobe
`timescale 1ns/1ns
`include "smc_consts.vh"
module smc_sync (
	input wire clk_i, // Clock
	input wire rst_n_i, // Sync reset, active low
	input wire smp_i, // Sampling strobe
	input wire rst_val_i, // Value held in reset
	input wire d_i, // Raw comparator level
	output reg q_o // Synchronised level
);
	reg meta;
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			meta <= rst_val_i;
			q_o <= rst_val_i;
		end else if (smp_i) begin
			meta <= d_i;
			q_o <= meta;
		end
	end
endmodule // smc_sync

// ---- rtl/smc_top.v ----
// Supply monitor control: enables, protection, flags and wake requests
`timescale 1ns/1ns
`include "smc_consts.vh"
// Operation
// - Enable and brown-out registers survive soft resets
// - Crossing and brown-out detections gated until settle time elapses
// - Crossing flag held zero while detector off
// - Writing 0 clears flag, 1 ignored
// - Wake bit governs wait only when clock stopped
// - Brown-out enable effective only with detector 0
// - Interrupt on warn crossing either direction
// - Merge onto shared watchdog/oscillation vector
// - Flag set on crossing; rise requests interrupt
// - Stop mode: request while above warn level
// - Request follows level after sample; wait rises
// - Sampling clock is CPU clock /8,/16,/32,/64
// - Level reads 1 while detector disabled
module smc_top (
	input wire MCLK_I, // CPU clock, 100 MHz
	input wire RESETN_I, // Full reset, active low
	input wire SOFT_RESETN_I, // Soft/watchdog/osc-stop reset, active low
	input wire PROTECT_WRITE_ENABLE_I, // Write-protect release
	input wire WR_DET_EN_I, // Write strobe, enable register
	input wire DET0_ENABLE_I, // Write data
	input wire LVD_ENABLE_I, // Write data
	input wire WR_LVD_CTRL_I, // Write strobe, interrupt control
	input wire LVD_IRQ_ENABLE_I, // Write data
	input wire LVD_WAKE_ENABLE_I, // Write data
	input wire LVD_CROSSED_FLAG_I, // Write data, 0 clears
	input wire [1:0] LVD_SAMPLE_DIV_I, // Write data
	input wire WR_BOR_CTRL_I, // Write strobe, brown-out control
	input wire BOR_ENABLE_I, // Write data
	input wire BOR_FILTER_DISABLE_I, // Write data
	input wire [1:0] BOR_FILTER_CLK_SEL_I, // Write data
	input wire PERIPH_CLK_STOP_IN_WAIT_I, // Peripheral clock stops in wait
	input wire LOWSPEED_OSC_STOP_I, // Low-speed oscillator stopped
	input wire LOSC_TICK_I, // Low-speed oscillator tick
	input wire [1:0] POWER_MODE_I, // Normal, wait or stop
	input wire DET0_CMP_I, // Comparator 0: supply above level 0
	input wire WARN_CMP_I, // Comparator 2: supply above warn level
	input wire WDT_IRQ_I, // Watchdog interrupt
	input wire OSC_IRQ_I, // Oscillation stop/restart interrupt
	output reg DET0_ENABLE_O, // Register readback
	output reg LVD_ENABLE_O, // Register readback
	output reg VCC_ABOVE_LEVEL_O, // Supply at or above warn level
	output reg LVD_IRQ_ENABLE_O, // Register readback
	output reg LVD_WAKE_ENABLE_O, // Register readback
	output reg LVD_CROSSED_FLAG_O, // Sticky crossing flag
	output reg [1:0] LVD_SAMPLE_DIV_O, // Register readback
	output reg BOR_ENABLE_O, // Register readback
	output reg BOR_FILTER_DISABLE_O, // Register readback
	output reg [1:0] BOR_FILTER_CLK_SEL_O, // Register readback
	output reg BOR_RESET_O, // Brown-out reset request
	output reg SHARED_IRQ_O, // Shared vector interrupt request
	output reg WAKE_O // Exit stop or wait
);
	reg [`SMC_DIV_W-1:0] div_cnt;
	reg [`SMC_DIV_W-1:0] div_last;
	reg smp;
	reg [`SMC_LOSC_DIV_W-1:0] losc_cnt;
	reg fsmp;
	reg [`SMC_FILT_W-1:0] filt_cnt;
	reg filt_low;
	reg lvl_d;
	reg lvd_irq;
	reg wake_hold;
	reg wake_armed;
	wire det0_ready;
	wire lvd_ready;
	wire det0_s;
	wire warn_s;
	wire lvd_live;
	wire det0_live;
	wire lvd_lvl;
	wire wr_ok_en;
	wire wr_ok_ctl;
	wire wr_ok_bor;
	wire crossed;
	wire in_wait;
	wire in_stop;
	wire wait_gated;
	wire next_flag;
	wire stop_hit;

	// Last count of the divider for a given code
	function [`SMC_DIV_W-1:0] div_end;
		input [1:0] code;
		begin
			case (code)
			2'h0: div_end = `SMC_DIV8;
			2'h1: div_end = `SMC_DIV16;
			2'h2: div_end = `SMC_DIV32;
			default: div_end = `SMC_DIV64;
			endcase
		end
	endfunction

	// Refused writes give no indication; software must read back
	assign wr_ok_en = WR_DET_EN_I & PROTECT_WRITE_ENABLE_I;
	assign wr_ok_ctl = WR_LVD_CTRL_I & PROTECT_WRITE_ENABLE_I;
	assign wr_ok_bor = WR_BOR_CTRL_I & PROTECT_WRITE_ENABLE_I;

	// Enable and brown-out registers reset only by the full reset
	always @(posedge MCLK_I) begin
		if (!RESETN_I) begin
			DET0_ENABLE_O <= 1'b0;
			LVD_ENABLE_O <= 1'b0;
			BOR_ENABLE_O <= 1'b0;
			BOR_FILTER_DISABLE_O <= 1'b1;
			BOR_FILTER_CLK_SEL_O <= 2'h0;
		end else begin
			if (wr_ok_en) begin
				DET0_ENABLE_O <= DET0_ENABLE_I;
				LVD_ENABLE_O <= LVD_ENABLE_I;
			end
			if (wr_ok_bor) begin
				BOR_ENABLE_O <= BOR_ENABLE_I;
				BOR_FILTER_DISABLE_O <= BOR_FILTER_DISABLE_I;
				BOR_FILTER_CLK_SEL_O <= BOR_FILTER_CLK_SEL_I;
			end
		end
	end

	smc_settle u_settle0 (
		.clk_i(MCLK_I),
		.rst_n_i(RESETN_I),
		.en_i(DET0_ENABLE_O),
		.ready_o(det0_ready)
	);
	smc_settle u_settle2 (
		.clk_i(MCLK_I),
		.rst_n_i(RESETN_I),
		.en_i(LVD_ENABLE_O),
		.ready_o(lvd_ready)
	);

	// Sampling divider for the warn comparator
	always @(posedge MCLK_I) begin
		if (!RESETN_I) begin
			div_cnt <= {`SMC_DIV_W{1'b0}};
			smp <= 1'b0;
		end else begin
			smp <= (div_cnt >= div_last);
			if (div_cnt >= div_last)
				div_cnt <= {`SMC_DIV_W{1'b0}};
			else
				div_cnt <= div_cnt + 1'b1;
		end
	end
	always @* begin
		div_last = div_end(LVD_SAMPLE_DIV_O);
	end

	// Filter sampling from the low-speed oscillator, /1 /2 /4 /8
	always @(posedge MCLK_I) begin
		if (!RESETN_I) begin
			losc_cnt <= {`SMC_LOSC_DIV_W{1'b0}};
			fsmp <= 1'b0;
		end else begin
			fsmp <= 1'b0;
			if (LOSC_TICK_I && !LOWSPEED_OSC_STOP_I) begin
				losc_cnt <= losc_cnt + 1'b1;
				fsmp <= ((losc_cnt & ((3'h1 << BOR_FILTER_CLK_SEL_O) - 3'h1)) == 3'h0);
			end
		end
	end

	// Brown-out comparator sampled every clock when filter bypassed
	smc_sync u_sync0 (
		.clk_i(MCLK_I),
		.rst_n_i(RESETN_I),
		.smp_i(BOR_FILTER_DISABLE_O | fsmp),
		.rst_val_i(1'b1),
		.d_i(DET0_CMP_I),
		.q_o(det0_s)
	);
	smc_sync u_sync2 (
		.clk_i(MCLK_I),
		.rst_n_i(RESETN_I),
		.smp_i(smp),
		.rst_val_i(1'b1),
		.d_i(WARN_CMP_I),
		.q_o(warn_s)
	);

	assign det0_live = DET0_ENABLE_O & det0_ready;
	assign lvd_live = LVD_ENABLE_O & lvd_ready;
	assign lvd_lvl = lvd_live ? warn_s : 1'b1;
	assign crossed = lvd_live & smp & (lvd_lvl != lvl_d);
	assign in_wait = (POWER_MODE_I == `SMC_MODE_WAIT);
	assign in_stop = (POWER_MODE_I == `SMC_MODE_STOP);
	assign wait_gated = in_wait & PERIPH_CLK_STOP_IN_WAIT_I;
	// Stop wake fires once per arming write
	assign stop_hit = LVD_ENABLE_O & LVD_IRQ_ENABLE_O & in_stop & LVD_WAKE_ENABLE_O
		& wake_armed & lvd_lvl;

	// Set wins over a software clear in the same cycle
	assign next_flag = crossed ? 1'b1 :
		((wr_ok_ctl && !LVD_CROSSED_FLAG_I) ? 1'b0 : LVD_CROSSED_FLAG_O);

	// Brown-out filter: four consecutive low samples
	always @(posedge MCLK_I) begin
		if (!RESETN_I || !det0_live || det0_s) begin
			filt_cnt <= {`SMC_FILT_W{1'b0}};
			filt_low <= 1'b0;
		end else if (BOR_FILTER_DISABLE_O) begin
			filt_low <= 1'b1;
		end else if (fsmp) begin
			if (filt_cnt == `SMC_FILT_LAST)
				filt_low <= 1'b1;
			else
				filt_cnt <= filt_cnt + 1'b1;
		end
	end

	// Interrupt control register, cleared by every reset source
	always @(posedge MCLK_I) begin
		if (!RESETN_I || !SOFT_RESETN_I) begin
			LVD_IRQ_ENABLE_O <= 1'b0;
			LVD_WAKE_ENABLE_O <= 1'b0;
			LVD_SAMPLE_DIV_O <= 2'h0;
		end else if (wr_ok_ctl) begin
			LVD_IRQ_ENABLE_O <= LVD_IRQ_ENABLE_I;
			LVD_WAKE_ENABLE_O <= LVD_WAKE_ENABLE_I;
			LVD_SAMPLE_DIV_O <= LVD_SAMPLE_DIV_I;
		end
	end

	// Crossing flag, level status and level at the last sample
	always @(posedge MCLK_I) begin
		if (!RESETN_I || !SOFT_RESETN_I) begin
			LVD_CROSSED_FLAG_O <= 1'b0;
			VCC_ABOVE_LEVEL_O <= 1'b1;
			lvl_d <= 1'b1;
		end else begin
			LVD_CROSSED_FLAG_O <= LVD_ENABLE_O ? next_flag : 1'b0;
			VCC_ABOVE_LEVEL_O <= lvd_lvl;
			if (smp)
				lvl_d <= lvd_lvl;
		end
	end

	// A used wake disarms; only a fresh 0-to-1 write rearms it
	always @(posedge MCLK_I) begin
		if (!RESETN_I || !SOFT_RESETN_I) begin
			wake_armed <= 1'b0;
		end else if (stop_hit) begin
			wake_armed <= 1'b0;
		end else if (wr_ok_ctl && LVD_WAKE_ENABLE_I && !LVD_WAKE_ENABLE_O) begin
			wake_armed <= 1'b1;
		end
	end

	// One-cycle request and wake, chosen by power mode
	always @(posedge MCLK_I) begin
		if (!RESETN_I || !SOFT_RESETN_I) begin
			lvd_irq <= 1'b0;
			wake_hold <= 1'b0;
		end else begin
			lvd_irq <= 1'b0;
			wake_hold <= 1'b0;
			if (LVD_ENABLE_O && LVD_IRQ_ENABLE_O) begin
				if (in_stop) begin
					if (stop_hit) begin
						lvd_irq <= 1'b1;
						wake_hold <= 1'b1;
					end
				end else if (wait_gated) begin
					if (LVD_WAKE_ENABLE_O && crossed && lvd_lvl) begin
						lvd_irq <= 1'b1;
						wake_hold <= 1'b1;
					end
				end else if (crossed && !LVD_CROSSED_FLAG_O) begin
					lvd_irq <= 1'b1;
					wake_hold <= in_wait;
				end
			end
		end
	end

	// Outputs registered once more so each leaves a flip-flop
	always @(posedge MCLK_I) begin
		if (!RESETN_I || !SOFT_RESETN_I) begin
			BOR_RESET_O <= 1'b0;
			SHARED_IRQ_O <= 1'b0;
			WAKE_O <= 1'b0;
		end else begin
			SHARED_IRQ_O <= lvd_irq | WDT_IRQ_I | OSC_IRQ_I;
			WAKE_O <= wake_hold;
			BOR_RESET_O <= BOR_ENABLE_O & det0_live & filt_low;
		end
	end
endmodule // smc_top
